// *** core/pmoc_consts.svh ***
// Command codes, field positions, reset values and timing for the output control block.
`ifndef PMOC_CONSTS_SVH
`define PMOC_CONSTS_SVH
`define PMOC_CMD_PAGE 8'h00
`define PMOC_CMD_OP 8'h01
`define PMOC_CMD_CFG 8'h02
`define PMOC_CMD_CLR 8'h03
`define PMOC_CMD_SDEF 8'h11
`define PMOC_CMD_RDEF 8'h12
`define PMOC_CMD_SUSR 8'h15
`define PMOC_CMD_RUSR 8'h16
`define PMOC_CMD_VMODE 8'h20
`define PMOC_CMD_VCMD 8'h21
`define PMOC_CMD_TRIM 8'h22
`define PMOC_CMD_CAL 8'h23
`define PMOC_CMD_MAX 8'h24
`define PMOC_CMD_MHI 8'h25
`define PMOC_CMD_MLO 8'h26
`define PMOC_IX_PAGE 4'h0
`define PMOC_IX_OP 4'h1
`define PMOC_IX_CFG 4'h2
`define PMOC_IX_VCMD 4'h3
`define PMOC_IX_TRIM 4'h4
`define PMOC_IX_CAL 4'h5
`define PMOC_IX_MAX 4'h6
`define PMOC_IX_MHI 4'h7
`define PMOC_IX_MLO 4'h8
`define PMOC_IX_NONE 4'hF
`define PMOC_NREG 9
`define PMOC_OP_EN 7:6
`define PMOC_OP_MG 5:4
`define PMOC_EN_IMM 2'h0
`define PMOC_EN_SOFT 2'h1
`define PMOC_EN_ON 2'h2
`define PMOC_MG_NOM 2'h0
`define PMOC_MG_LOW 2'h1
`define PMOC_MG_HIGH 2'h2
`define PMOC_FLD_BAD 2'h3
`define PMOC_CFG_PWRUP 4
`define PMOC_CFG_BUS 3
`define PMOC_CFG_PIN 2
`define PMOC_CFG_POL 1
`define PMOC_CFG_FAST 0
`define PMOC_VMODE_DEF 8'h14
`define PMOC_RST_OP 16'h0000
`define PMOC_RST_CFG 16'h0016
`define PMOC_RST_VOUT 16'h0000
`define PMOC_TRIM_LIM_MV 150
`define PMOC_LSB_PER_V 4096
`define PMOC_MAX_PCT 24'h000073
`define PMOC_PCT_DIV 24'h000064
`define PMOC_NVM_WAIT_MS 20
`define PMOC_CLK_KHZ 250000
`define PMOC_SYNC_CNT 2'h2
`endif

// *** core/pmoc_ctrl.sv ***
// Output control command interpreter: enable, margining, setpoint and configuration store.
// Function
// - Operation enable field acts only when bus enable mode is configured.
// - Enable codes: 00 immediate off, 01 soft off, 10 on with ramp.
// - Margin codes: 00 nominal, 01 margin low, 10 margin high.
// - Power-up bit set: output waits for pin and bus enable, as their mode bits require.
// - Bus mode bit: 0 ignores bus on/off, 1 requires bus on.
// - Pin mode bit: 0 ignores pin, 1 requires pin asserted.
// - Polarity bit 1 makes the control pin active high.
// - Pin turn-off method: 0 soft off, 1 immediate off.
// - Code 0x03 clears every fault status bit.
// - Code 0x11 saves configuration to default store; protected by default.
// - Code 0x12 reloads working configuration from default store.
// - Code 0x15 saves settings written since last restore to user store.
// - Code 0x16 reloads user store over defaults; also runs at power-up.
// - User restore sets security level to one.
// - Mode byte is read-only; bits 4:0 are a signed exponent.
// - Mode bits 7:5 give encoding: linear, VID or direct.
// - Setpoint is a 16-bit unsigned read/write word.
// - Trim is a signed offset added to setpoint, limited to 150 mV.
// - Calibration offset is signed and added like trim, but without the trim limit.
// - Target clamps at ceiling; ceiling capped at 115 percent of strap.
// - Margin words replace the setpoint in the target while their margin state is selected.
`timescale 1ns/100ps
`include "pmoc_consts.svh"

module pmoc_ctrl #(
  parameter int unsigned NVM_WAIT_CYC = `PMOC_NVM_WAIT_MS * `PMOC_CLK_KHZ,
  parameter logic [17:0] TRIM_LIM_CODE = 18'((`PMOC_TRIM_LIM_MV * `PMOC_LSB_PER_V) / 1000),
  parameter logic [7:0] VMODE = `PMOC_VMODE_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire pmoc_pkg::pmoc_word_t i_cmd_data,
  input wire logic i_default_store_unlock,
  input wire logic i_ctrl_pin,
  input wire pmoc_pkg::pmoc_word_t i_voltage_set_strap_pin,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic o_rsp_err,
  output pmoc_pkg::pmoc_word_t o_rsp_data,
  output logic o_out_enable,
  output logic o_off_fast,
  output logic [1:0] o_margin_sel,
  output pmoc_pkg::pmoc_word_t o_target_code,
  output logic o_clear_faults,
  output logic o_nvm_busy,
  output logic [1:0] o_security_level
);
  import pmoc_pkg::*;

  localparam int WCW = $clog2(NVM_WAIT_CYC + 1);
  localparam int NR = `PMOC_NREG;

  function automatic logic [3:0] code_ix(input logic [7:0] c);
    case (c)
      `PMOC_CMD_PAGE: code_ix = `PMOC_IX_PAGE;
      `PMOC_CMD_OP: code_ix = `PMOC_IX_OP;
      `PMOC_CMD_CFG: code_ix = `PMOC_IX_CFG;
      `PMOC_CMD_VCMD: code_ix = `PMOC_IX_VCMD;
      `PMOC_CMD_TRIM: code_ix = `PMOC_IX_TRIM;
      `PMOC_CMD_CAL: code_ix = `PMOC_IX_CAL;
      `PMOC_CMD_MAX: code_ix = `PMOC_IX_MAX;
      `PMOC_CMD_MHI: code_ix = `PMOC_IX_MHI;
      `PMOC_CMD_MLO: code_ix = `PMOC_IX_MLO;
      default: code_ix = `PMOC_IX_NONE;
    endcase
  endfunction

  function automatic pmoc_word_t rst_val(input int i);
    if (i == int'(`PMOC_IX_OP)) begin
      rst_val = `PMOC_RST_OP;
    end else if (i == int'(`PMOC_IX_CFG)) begin
      rst_val = `PMOC_RST_CFG;
    end else begin
      rst_val = `PMOC_RST_VOUT;
    end
  endfunction

  function automatic logic [17:0] sx18(input pmoc_word_t w);
    sx18 = {{2{w[15]}}, w};
  endfunction

  pmoc_state_e state_r;
  pmoc_word_t cfg_r [NR];
  pmoc_word_t def_r [NR];
  pmoc_word_t usr_r [NR];
  logic [NR-1:0] dirty_r;
  logic [NR-1:0] usr_vld_r;
  logic [WCW-1:0] wait_r;
  logic [1:0] boot_cnt_r;
  logic ctrl_s1_r;
  logic ctrl_s2_r;
  pmoc_word_t strap_s1_r;
  pmoc_word_t strap_s2_r;
  pmoc_word_t strap_r;
  logic op_on_r;
  logic bus_fast_r;
  logic en_r;
  logic off_fast_r;
  logic [1:0] margin_r;
  pmoc_word_t target_r;
  logic rsp_valid_r;
  logic rsp_err_r;
  pmoc_word_t rsp_data_r;
  logic clr_r;
  logic [1:0] sec_r;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.
  wire logic acc = i_cmd_valid && o_cmd_ready;
  wire logic wr = acc && i_cmd_write;
  wire logic rd = acc && !i_cmd_write;
  wire logic [3:0] ix = code_ix(i_cmd_code);
  wire logic reg_hit = ix != `PMOC_IX_NONE;
  wire logic is_mode = i_cmd_code == `PMOC_CMD_VMODE;
  wire logic do_clr = wr && i_cmd_code == `PMOC_CMD_CLR;
  wire logic sdef_cmd = wr && i_cmd_code == `PMOC_CMD_SDEF;
  wire logic do_sdef = sdef_cmd && i_default_store_unlock;
  wire logic sdef_locked = sdef_cmd && !i_default_store_unlock;
  wire logic do_rdef = wr && i_cmd_code == `PMOC_CMD_RDEF;
  wire logic do_susr = wr && i_cmd_code == `PMOC_CMD_SUSR;
  wire logic boot_go = state_r == PMOC_ST_BOOT && boot_cnt_r == `PMOC_SYNC_CNT;
  wire logic do_rusr = (wr && i_cmd_code == `PMOC_CMD_RUSR) || boot_go;
  wire logic is_send = do_clr || sdef_cmd || do_rdef || do_susr || do_rusr;
  wire logic do_wr = wr && reg_hit;
  wire logic cmd_err = (wr && !reg_hit && !is_send) || (rd && !reg_hit && !is_mode) || sdef_locked;
  wire logic [3:0] op_ix = `PMOC_IX_OP;

  assign o_cmd_ready = state_r == PMOC_ST_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // Write value shaping: byte registers keep the low byte; the ceiling is capped by the strap.
  wire logic [23:0] max_prod = {8'h00, strap_r} * `PMOC_MAX_PCT;
  wire logic [23:0] max_lim24 = max_prod / `PMOC_PCT_DIV;
  wire pmoc_word_t max_lim = (max_lim24 > 24'h00FFFF) ? 16'hFFFF : max_lim24[15:0];
  wire logic is_byte = ix <= `PMOC_IX_CFG;
  wire logic cap_max = ix == `PMOC_IX_MAX && i_cmd_data > max_lim;
  wire pmoc_word_t wr_val = cap_max ? max_lim : (is_byte ? {8'h00, i_cmd_data[7:0]} : i_cmd_data);

  //////////////////////////////////////////////////////////////////////////////
  // Read path; the mode byte is a constant and answers reads only.
  wire pmoc_word_t rd_val = is_mode ? {8'h00, VMODE} : (reg_hit ? cfg_r[ix] : 16'h0000);

  //////////////////////////////////////////////////////////////////////////////
  // Operation byte effects.
  wire logic [1:0] op_en = i_cmd_data[`PMOC_OP_EN];
  wire logic [1:0] op_mg = i_cmd_data[`PMOC_OP_MG];
  wire logic op_wr = do_wr && ix == op_ix;
  wire logic op_en_upd = op_wr && cfg_r[`PMOC_IX_CFG][`PMOC_CFG_BUS] && op_en != `PMOC_FLD_BAD;
  wire logic op_mg_upd = op_wr && op_mg != `PMOC_FLD_BAD;

  //////////////////////////////////////////////////////////////////////////////
  // Enable arbitration between power-up mode, control pin and bus.
  wire pmoc_word_t cfg_w = cfg_r[`PMOC_IX_CFG];
  wire logic pin_act = cfg_w[`PMOC_CFG_POL] ? ctrl_s2_r : !ctrl_s2_r;
  wire logic pin_ok = !cfg_w[`PMOC_CFG_PIN] || pin_act;
  wire logic bus_ok = !cfg_w[`PMOC_CFG_BUS] || op_on_r;
  wire logic en_nxt = state_r != PMOC_ST_BOOT && (!cfg_w[`PMOC_CFG_PWRUP] || (pin_ok && bus_ok));
  wire logic off_fast_nxt = !bus_ok ? bus_fast_r : cfg_w[`PMOC_CFG_FAST];

  //////////////////////////////////////////////////////////////////////////////
  // Target: selected word plus limited trim plus calibration, clamped to zero and the ceiling.
  wire pmoc_word_t sel_w = (margin_r == `PMOC_MG_LOW) ? cfg_r[`PMOC_IX_MLO] :
                           (margin_r == `PMOC_MG_HIGH) ? cfg_r[`PMOC_IX_MHI] : cfg_r[`PMOC_IX_VCMD];
  wire logic signed [17:0] trim_s = signed'(sx18(cfg_r[`PMOC_IX_TRIM]));
  wire logic signed [17:0] lim_s = signed'(TRIM_LIM_CODE);
  wire logic signed [17:0] trim_c = (trim_s > lim_s) ? lim_s : ((trim_s < -lim_s) ? -lim_s : trim_s);
  wire logic signed [17:0] cal_s = signed'(sx18(cfg_r[`PMOC_IX_CAL]));
  wire logic signed [17:0] sum_s = signed'({2'b00, sel_w}) + trim_c + cal_s;
  wire pmoc_word_t vmax = cfg_r[`PMOC_IX_MAX];
  wire pmoc_word_t tgt_w = (sum_s < 18'sh00000) ? 16'h0000 :
                           ((sum_s > signed'({2'b00, vmax})) ? vmax : sum_s[15:0]);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers and strap capture. The strap is sampled on each boot cycle after reset release, then held.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_s1_r <= 1'b0;
      ctrl_s2_r <= 1'b0;
      strap_s1_r <= 16'h0000;
      strap_s2_r <= 16'h0000;
    end else begin
      ctrl_s1_r <= i_ctrl_pin;
      ctrl_s2_r <= ctrl_s1_r;
      strap_s1_r <= i_voltage_set_strap_pin;
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      boot_cnt_r <= 2'h0;
      strap_r <= 16'h0000;
    end else if (state_r == PMOC_ST_BOOT) begin
      // Only the second stage is read, so a metastable first stage never reaches the ceiling cap.
      // The boot count gives the pin value time to arrive there before the restore fires.
      if (boot_cnt_r != `PMOC_SYNC_CNT) begin
        boot_cnt_r <= boot_cnt_r + 2'h1;
      end
      strap_r <= strap_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: power-up restore, then a busy window after each user store or restore.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_r <= PMOC_ST_BOOT;
      wait_r <= '0;
    end else begin
      unique case (state_r)
        PMOC_ST_BOOT: begin
          if (boot_go) begin
            state_r <= PMOC_ST_BUSY;
            wait_r <= WCW'(NVM_WAIT_CYC - 1);
          end
        end
        PMOC_ST_IDLE: begin
          if (do_susr || do_rusr) begin
            state_r <= PMOC_ST_BUSY;
            wait_r <= WCW'(NVM_WAIT_CYC - 1);
          end
        end
        PMOC_ST_BUSY: begin
          if (wait_r == '0) begin
            state_r <= PMOC_ST_IDLE;
          end else begin
            wait_r <= wait_r - WCW'(1);
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Working and store arrays. The default store is reset to factory values and the user store is cleared here, so this model
  // loses user contents on reset; a real nonvolatile macro keeps them across power cycles.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < NR; i++) begin
        cfg_r[i] <= rst_val(i);
        def_r[i] <= rst_val(i);
        usr_r[i] <= 16'h0000;
      end
      dirty_r <= '0;
      usr_vld_r <= '0;
    end else if (do_rusr) begin
      for (int i = 0; i < NR; i++) begin
        cfg_r[i] <= usr_vld_r[i] ? usr_r[i] : def_r[i];
      end
      dirty_r <= '0;
    end else if (do_rdef) begin
      for (int i = 0; i < NR; i++) begin
        cfg_r[i] <= def_r[i];
      end
      dirty_r <= '0;
    end else if (do_susr) begin
      for (int i = 0; i < NR; i++) begin
        if (dirty_r[i]) begin
          usr_r[i] <= cfg_r[i];
        end
      end
      usr_vld_r <= usr_vld_r | dirty_r;
    end else if (do_sdef) begin
      for (int i = 0; i < NR; i++) begin
        def_r[i] <= cfg_r[i];
      end
    end else if (do_wr) begin
      cfg_r[ix] <= wr_val;
      dirty_r[ix] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output state.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      op_on_r <= 1'b0;
      bus_fast_r <= 1'b0;
      margin_r <= `PMOC_MG_NOM;
      en_r <= 1'b0;
      off_fast_r <= 1'b0;
      target_r <= 16'h0000;
    end else begin
      if (op_en_upd) begin
        op_on_r <= op_en == `PMOC_EN_ON;
        bus_fast_r <= op_en == `PMOC_EN_IMM;
      end
      if (op_mg_upd) begin
        margin_r <= op_mg;
      end
      en_r <= en_nxt;
      if (en_r && !en_nxt) begin
        off_fast_r <= off_fast_nxt;
      end
      target_r <= tgt_w;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      clr_r <= 1'b0;
      sec_r <= 2'h0;
    end else begin
      rsp_valid_r <= acc;
      rsp_err_r <= acc && cmd_err;
      rsp_data_r <= rd ? rd_val : 16'h0000;
      clr_r <= do_clr;
      if (do_rusr) begin
        sec_r <= 2'h1;
      end
    end
  end

  assign o_rsp_valid = rsp_valid_r;
  assign o_rsp_err = rsp_err_r;
  assign o_rsp_data = rsp_data_r;
  assign o_out_enable = en_r;
  assign o_off_fast = off_fast_r;
  assign o_margin_sel = margin_r;
  assign o_target_code = target_r;
  assign o_clear_faults = clr_r;
  assign o_nvm_busy = state_r != PMOC_ST_IDLE;
  assign o_security_level = sec_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  chk_op_ignored: assert property (op_wr && !cfg_w[`PMOC_CFG_BUS] |=> $stable(op_on_r))
    else $error("operation enable acted while bus mode off");
  // An immediate off while the output is already off leaves the last turn-off method in place.
  chk_imm_off: assert property (op_en_upd && op_en == `PMOC_EN_IMM && en_r && en_nxt
    && cfg_w[`PMOC_CFG_PWRUP] |=> !op_on_r ##1 (!en_r && off_fast_r))
    else $error("immediate off not applied");
  chk_margin_sel: assert property (op_wr && op_mg == `PMOC_MG_HIGH |=> margin_r == `PMOC_MG_HIGH)
    else $error("margin high not selected");
  chk_pin_gate: assert property (cfg_w[`PMOC_CFG_PWRUP] && cfg_w[`PMOC_CFG_PIN] && !pin_act |=> !en_r)
    else $error("output enabled without control pin");
  chk_clear_pulse: assert property (do_clr |=> o_clear_faults ##1 (!o_clear_faults || $past(do_clr)))
    else $error("clear faults pulse wrong");
  chk_store_lock: assert property (sdef_locked |=> o_rsp_valid && o_rsp_err)
    else $error("locked default store not refused");
  chk_sec_level: assert property (do_rusr |=> o_security_level == 2'h1 && o_nvm_busy)
    else $error("security level not set after user restore");
  chk_mode_ro: assert property (wr && is_mode |=> o_rsp_err && $stable(o_security_level))
    else $error("mode byte write accepted");
  chk_max_clamp: assert property (##1 o_target_code <= $past(vmax))
    else $error("target above ceiling");
  chk_ceiling_cap: assert property (do_wr && ix == `PMOC_IX_MAX |=> vmax <= max_lim)
    else $error("ceiling stored above strap limit");
  chk_pin_method: assert property (en_r && !en_nxt && bus_ok |=> !o_out_enable
    && o_off_fast == $past(cfg_w[`PMOC_CFG_FAST]))
    else $error("pin turn-off method not applied");
  chk_field_bad: assert property (op_wr && op_mg == `PMOC_FLD_BAD |=> $stable(margin_r))
    else $error("undefined margin code changed state");

  cov_margin_low: cover property (op_mg_upd && op_mg == `PMOC_MG_LOW);
  cov_user_store: cover property (do_susr);
  cov_pin_off: cover property (en_r && !en_nxt && bus_ok);

  // Bus enable and default reload complete the set of main scenarios.
  cov_bus_on: cover property (op_en_upd && op_en == `PMOC_EN_ON);
  cov_default_reload: cover property (do_rdef);
endmodule // pmoc_ctrl

// *** core/pmoc_pkg.sv ***
// Types shared by the output control block.
package pmoc_pkg;
  typedef logic [15:0] pmoc_word_t;
  typedef enum logic [1:0] {PMOC_ST_BOOT, PMOC_ST_IDLE, PMOC_ST_BUSY} pmoc_state_e;
endpackage

// *** verif/pmoc_host_model.sv ***
// Host model that issues commands on the command port of the output control block.
`timescale 1ns/100ps
module pmoc_host_model #(
  parameter int WAIT_CYC = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_err,
  input wire pmoc_pkg::pmoc_word_t i_rsp_data,
  output logic o_cmd_valid,
  output logic o_cmd_write,
  output logic [7:0] o_cmd_code,
  output pmoc_pkg::pmoc_word_t o_cmd_data
);
  import pmoc_pkg::*;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code = 8'hFF;
    o_cmd_data = 16'h5A5A;
  end

  // A missing answer comes back as an unknown error flag so that the caller's compare fails.
  task automatic xfer(input logic wr, input logic [7:0] code, input pmoc_word_t data,
                      output logic err, output pmoc_word_t rd);
    int n = 0;
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b1;
    o_cmd_write <= wr;
    o_cmd_code <= code;
    o_cmd_data <= data;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_cmd_ready !== 1'b1 && n < 2000);
    // Released lines show the inverse so that stale values cannot pass for fresh ones.
    o_cmd_valid <= 1'b0;
    o_cmd_write <= ~wr;
    o_cmd_code <= ~code;
    o_cmd_data <= ~data;
    @(posedge i_clk_sys);
    err = (i_rsp_valid === 1'b1) ? i_rsp_err : 1'bx;
    rd = i_rsp_data;
    if (wr && (code == 8'h15 || code == 8'h16)) repeat (WAIT_CYC + 2) @(posedge i_clk_sys);
  endtask
endmodule // pmoc_host_model

// *** verif/tb_pmbus_output_control_commands.sv ***
// Self-checking testbench for the output control command interpreter.
`timescale 1ns/100ps
`define PMOC_TB_CHK(got, exp) chk_val(16'(got), 16'(exp))
module tb_pmbus_output_control_commands;
  import pmoc_pkg::*;
  localparam int WAIT_CYC = 16;
  typedef struct packed {
    logic wr; logic [7:0] code; pmoc_word_t data; logic err; pmoc_word_t rd; pmoc_word_t tgt; logic [1:0] mg;
  } pmoc_tb_row_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic unlock = 1'b0;
  logic pin = 1'b0;
  pmoc_word_t strap = 16'h2000;
  logic valid, cmd_wr, ready, rsp_v, rsp_e, en, fast, clr, busy;
  logic [7:0] code;
  logic [1:0] mg, sec;
  pmoc_word_t data, rsp_d, tgt, rd;
  logic err;
  int n_errors = 0;
  int samples_checked = 0;
  int n_clr = 0;
  pmoc_tb_row_s rows [0:22] = '{
    '{1'b0, 8'h20, 16'h0000, 1'b0, 16'h0014, 16'h0000, 2'h0},
    '{1'b1, 8'h20, 16'h1234, 1'b1, 16'h0000, 16'h0000, 2'h0},
    '{1'b0, 8'h02, 16'h0000, 1'b0, 16'h0016, 16'h0000, 2'h0},
    '{1'b1, 8'h21, 16'h1000, 1'b0, 16'h0000, 16'h0000, 2'h0},
    '{1'b1, 8'h24, 16'hFFFF, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b0, 8'h24, 16'h0000, 1'b0, 16'h24CC, 16'h1000, 2'h0},
    '{1'b1, 8'h22, 16'h1000, 1'b0, 16'h0000, 16'h1266, 2'h0},
    '{1'b1, 8'h22, 16'hF000, 1'b0, 16'h0000, 16'h0D9A, 2'h0},
    '{1'b1, 8'h23, 16'h0010, 1'b0, 16'h0000, 16'h0DAA, 2'h0},
    '{1'b1, 8'h22, 16'h0000, 1'b0, 16'h0000, 16'h1010, 2'h0},
    '{1'b1, 8'h23, 16'h0000, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h21, 16'h3000, 1'b0, 16'h0000, 16'h24CC, 2'h0},
    '{1'b1, 8'h21, 16'h1000, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h25, 16'h1800, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h26, 16'h0800, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h01, 16'h0010, 1'b0, 16'h0000, 16'h0800, 2'h1},
    '{1'b1, 8'h01, 16'h0030, 1'b0, 16'h0000, 16'h0800, 2'h1},
    '{1'b1, 8'h01, 16'h0020, 1'b0, 16'h0000, 16'h1800, 2'h2},
    '{1'b1, 8'h01, 16'h0000, 1'b0, 16'h0000, 16'h1000, 2'h0},
    '{1'b0, 8'h03, 16'h0000, 1'b1, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h11, 16'h0000, 1'b1, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h99, 16'h0000, 1'b1, 16'h0000, 16'h1000, 2'h0},
    '{1'b1, 8'h00, 16'h01AB, 1'b0, 16'h0000, 16'h1000, 2'h0}
  };

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (clr === 1'b1) n_clr <= n_clr + 1;
  end

  pmoc_ctrl #(.NVM_WAIT_CYC(WAIT_CYC)) pmoc_ctrl_inst (.i_clk_sys(clk_sys), .i_reset(reset), .i_cmd_valid(valid),
    .i_cmd_write(cmd_wr), .i_cmd_code(code), .i_cmd_data(data), .i_default_store_unlock(unlock), .i_ctrl_pin(pin),
    .i_voltage_set_strap_pin(strap), .o_cmd_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_err(rsp_e),
    .o_rsp_data(rsp_d), .o_out_enable(en), .o_off_fast(fast), .o_margin_sel(mg), .o_target_code(tgt),
    .o_clear_faults(clr), .o_nvm_busy(busy), .o_security_level(sec));

  pmoc_host_model #(.WAIT_CYC(WAIT_CYC)) pmoc_host_model_inst (.i_clk_sys(clk_sys), .i_cmd_ready(ready),
    .i_rsp_valid(rsp_v), .i_rsp_err(rsp_e), .i_rsp_data(rsp_d), .o_cmd_valid(valid), .o_cmd_write(cmd_wr),
    .o_cmd_code(code), .o_cmd_data(data));

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checked %0d values, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic w, input logic [7:0] c, input pmoc_word_t d, input logic e);
    pmoc_host_model_inst.xfer(w, c, d, err, rd);
    `PMOC_TB_CHK(err, e);
    settle(3);
  endtask

  task automatic drive_pin(input logic v);
    @(posedge clk_sys);
    pin <= v;
    settle(6);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("Watchdog expired before the tests finished");
    end_of_test();
  end

  initial begin
    int c0;
    settle(20);
    `PMOC_TB_CHK({busy, ready, sec}, 4'h8);
    reset <= 1'b0;
    settle(6);
    `PMOC_TB_CHK({busy, sec}, 3'h5);
    for (int i = 0; i < 23; i++) begin
      pmoc_host_model_inst.xfer(rows[i].wr, rows[i].code, rows[i].data, err, rd);
      `PMOC_TB_CHK(err, rows[i].err);
      if (rows[i].err === 1'b0) `PMOC_TB_CHK(rd, rows[i].rd);
      settle(3);
      `PMOC_TB_CHK(tgt, rows[i].tgt);
      `PMOC_TB_CHK(mg, rows[i].mg);
    end
    cmd(1'b0, 8'h00, 16'h0000, 1'b0);
    `PMOC_TB_CHK(rd, 16'h00AB);
    // The reset configuration makes the pin the only enable source.
    drive_pin(1'b1);
    `PMOC_TB_CHK(en, 1'b1);
    cmd(1'b1, 8'h01, 16'h0000, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    drive_pin(1'b0);
    `PMOC_TB_CHK({en, fast}, 2'h0);
    cmd(1'b1, 8'h02, 16'h0017, 1'b0);
    drive_pin(1'b1);
    drive_pin(1'b0);
    `PMOC_TB_CHK({en, fast}, 2'h1);
    cmd(1'b1, 8'h02, 16'h0014, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    drive_pin(1'b1);
    `PMOC_TB_CHK(en, 1'b0);
    cmd(1'b1, 8'h02, 16'h001E, 1'b0);
    `PMOC_TB_CHK(en, 1'b0);
    cmd(1'b1, 8'h01, 16'h0080, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    cmd(1'b1, 8'h01, 16'h00C0, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    cmd(1'b1, 8'h01, 16'h0000, 1'b0);
    `PMOC_TB_CHK({en, fast}, 2'h1);
    cmd(1'b1, 8'h01, 16'h0080, 1'b0);
    cmd(1'b1, 8'h01, 16'h0040, 1'b0);
    `PMOC_TB_CHK({en, fast}, 2'h0);
    cmd(1'b1, 8'h02, 16'h001A, 1'b0);
    drive_pin(1'b0);
    cmd(1'b1, 8'h01, 16'h0080, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    cmd(1'b1, 8'h01, 16'h0000, 1'b0);
    cmd(1'b1, 8'h02, 16'h0002, 1'b0);
    `PMOC_TB_CHK(en, 1'b1);
    c0 = n_clr;
    cmd(1'b1, 8'h03, 16'h0000, 1'b0);
    `PMOC_TB_CHK(n_clr - c0, 1);
    // Only words written since the last restore reach the user store.
    cmd(1'b1, 8'h21, 16'h1111, 1'b0);
    cmd(1'b1, 8'h15, 16'h0000, 1'b0);
    cmd(1'b1, 8'h21, 16'h2222, 1'b0);
    cmd(1'b1, 8'h16, 16'h0000, 1'b0);
    cmd(1'b0, 8'h21, 16'h0000, 1'b0);
    `PMOC_TB_CHK(rd, 16'h1111);
    `PMOC_TB_CHK(sec, 2'h1);
    @(posedge clk_sys);
    unlock <= 1'b1;
    cmd(1'b1, 8'h21, 16'h0ABC, 1'b0);
    cmd(1'b1, 8'h11, 16'h0000, 1'b0);
    cmd(1'b1, 8'h21, 16'h0000, 1'b0);
    cmd(1'b1, 8'h12, 16'h0000, 1'b0);
    cmd(1'b0, 8'h21, 16'h0000, 1'b0);
    `PMOC_TB_CHK(rd, 16'h0ABC);
    @(posedge clk_sys);
    reset <= 1'b1;
    settle(3);
    `PMOC_TB_CHK({en, busy, ready, sec}, 5'h08);
    reset <= 1'b0;
    settle(6);
    `PMOC_TB_CHK(sec, 2'h1);
    end_of_test();
  end
endmodule // tb_pmbus_output_control_commands
